// *** shared/dcd_pkg.sv ***
// Package with command encodings, pin layout and register map of the command controller.
package dcd_pkg;

   localparam int BANK_W = 3;
   localparam int ADDR_W = 15;
   localparam int CHOP_POS = 12;
   localparam int CLOSE_POS = 10;

   // Register byte offsets on the AXI4-Lite slave.
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_CTRL   = 8'h0C;

   // Command register fields.
   localparam int CMD_CODE_LSB = 0;
   localparam int CMD_BANK_LSB = 8;
   localparam int CMD_CHOP_POS = 16;
   localparam int CMD_CLOSE_POS = 17;

   // Control register reset value: device reset released.
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;

   // Self-renew exit to first write guard, in device clock cycles.
   localparam int SR_WRITE_GUARD_NCK = 512;
   localparam logic [9:0] SR_GUARD_CYC = 10'(SR_WRITE_GUARD_NCK);

   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      DCD_IDLE       = 4'h0,
      DCD_CFG_LOAD   = 4'h1,
      DCD_REFRESH    = 4'h2,
      DCD_SR_ENTER   = 4'h3,
      DCD_SR_LEAVE   = 4'h4,
      DCD_CLOSE      = 4'h5,
      DCD_ALL_CLOSE  = 4'h6,
      DCD_ROW_OPEN   = 4'h7,
      DCD_STORE      = 4'h8,
      DCD_FETCH      = 4'h9,
      DCD_SLEEP_IN   = 4'hA,
      DCD_SLEEP_OUT  = 4'hB,
      DCD_CAL_LONG   = 4'hC,
      DCD_CAL_SHORT  = 4'hD,
      DCD_DESELECT   = 4'hE
   } dcd_cmd_t;

   // Pins driven toward the device, all held in flip-flops.
   typedef struct packed {
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic              cke;
      logic              reset_n;
      logic              termination_ctl;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] addr;
   } dcd_pins_t;

   typedef struct packed {
      logic             awvalid;
      logic [7:0]       awaddr;
      logic             wvalid;
      logic [31:0]      wdata;
      logic [3:0]       wstrb;
      logic             bready;
      logic             arvalid;
      logic [7:0]       araddr;
      logic             rready;
   } dcd_axi_req_t;

   typedef struct packed {
      logic             awready;
      logic             wready;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
   } dcd_axi_rsp_t;

endpackage : dcd_pkg

// *** design/dcd_pin_drive.sv ***
// Encoder that turns one requested command into registered device pin levels.
`timescale 1ns/100ps
module dcd_pin_drive (
   input  wire logic                         mclk_i,
   input  wire logic                         reset_i,
   input  wire logic                         fire_i,
   input  wire dcd_pkg::dcd_cmd_t            cmd_i,
   input  wire logic [dcd_pkg::BANK_W-1:0]   bank_i,
   input  wire logic [dcd_pkg::ADDR_W-1:0]   addr_i,
   input  wire logic                         chop_i,
   input  wire logic                         close_i,
   input  wire logic                         reset_n_i,
   input  wire logic                         term_i,
   output dcd_pkg::dcd_pins_t                pins_o
);

   dcd_pkg::dcd_pins_t pins_q;
   dcd_pkg::dcd_pins_t pins_d;
   logic               cke_q;

   assign pins_o = pins_q;

   always_comb begin
      pins_d = pins_q;
      // Between commands the bus carries the idle pattern with defined levels.
      {pins_d.cs_n, pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 4'h7;
      pins_d.cke     = cke_q;
      pins_d.reset_n = reset_n_i;
      pins_d.termination_ctl = term_i;
      pins_d.bank    = '0;
      pins_d.addr    = '0;
      if (fire_i) begin
         pins_d.bank = bank_i;
         unique case (cmd_i)
            dcd_pkg::DCD_CFG_LOAD: begin
               {pins_d.cs_n, pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 4'h0;
               pins_d.addr = addr_i;
            end
            dcd_pkg::DCD_REFRESH:
               {pins_d.cs_n, pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 4'h1;
            dcd_pkg::DCD_SR_ENTER: begin
               {pins_d.cs_n, pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 4'h1;
               pins_d.cke = 1'b0;
            end
            dcd_pkg::DCD_SR_LEAVE,
            dcd_pkg::DCD_SLEEP_OUT:
               pins_d.cke = 1'b1;
            dcd_pkg::DCD_SLEEP_IN:
               pins_d.cke = 1'b0;
            dcd_pkg::DCD_CLOSE,
            dcd_pkg::DCD_ALL_CLOSE: begin
               {pins_d.cs_n, pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 4'h2;
               pins_d.addr[dcd_pkg::CLOSE_POS] = (cmd_i == dcd_pkg::DCD_ALL_CLOSE);
            end
            dcd_pkg::DCD_ROW_OPEN: begin
               {pins_d.cs_n, pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 4'h3;
               pins_d.addr = addr_i;
            end
            dcd_pkg::DCD_STORE,
            dcd_pkg::DCD_FETCH: begin
               pins_d.cs_n  = 1'b0;
               pins_d.ras_n = 1'b1;
               pins_d.cas_n = 1'b0;
               pins_d.we_n  = (cmd_i == dcd_pkg::DCD_FETCH);
               pins_d.addr  = addr_i;
               pins_d.addr[dcd_pkg::CHOP_POS]  = chop_i;
               pins_d.addr[dcd_pkg::CLOSE_POS] = close_i;
            end
            dcd_pkg::DCD_CAL_LONG,
            dcd_pkg::DCD_CAL_SHORT: begin
               {pins_d.cs_n, pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 4'h6;
               pins_d.addr[dcd_pkg::CLOSE_POS] = (cmd_i == dcd_pkg::DCD_CAL_LONG);
            end
            dcd_pkg::DCD_DESELECT:
               pins_d.cs_n = 1'b1;
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         pins_q <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b0,
                     reset_n: 1'b0, termination_ctl: 1'b0, bank: '0, addr: '0};
         cke_q  <= 1'b0;
      end else begin
         pins_q <= pins_d;
         cke_q  <= pins_d.cke;
      end
   end

endmodule : dcd_pin_drive

// *** design/dcd_ctrl.sv ***
// Memory-side command controller: AXI4-Lite registers drive device command pins.
// Notes on behaviour
// - Commands are pin levels at a rising edge; we register every pin.
// - Config load drives all strobes low, bank selects register, address carries code.
// - Device reset line is held high during normal function.
// - Valid fields driven to defined levels; we drive zeros.
// - Store uses chip select, column strobe, write enable low, row strobe high.
// - Fetch uses chip select, column strobe low, row strobe, write enable high.
// - Close: autoclose bit low closes one bank, high closes all.
// - Impedance calibration: autoclose bit high long, low short.
// - Row open drives chip select and row strobe low.
// - Controller issues idle between operations.
// - Self-renew leave is clock enable rising with idle or deselect.
// - No store earlier than 512 cycles after self-renew leave.
// - Controller must schedule refresh; power-down does not refresh; we only send refresh when software writes it.
// - Self-renew entry only when all banks are idle; we check one open-bank flag, which any store or fetch with autoclose clears.
// - Only idle or deselect during sleep entry and exit.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module dcd_ctrl (
   input  wire logic                  mclk_i,
   input  wire logic                  reset_i,
   input  wire dcd_pkg::dcd_axi_req_t axi_req_i,
   output dcd_pkg::dcd_axi_rsp_t      axi_rsp_o,
   output dcd_pkg::dcd_pins_t         pins_o
);

   // Write channel state.
   logic                 aw_hold_q;
   logic [7:0]           aw_addr_q;
   logic                 w_hold_q;
   logic [31:0]          w_data_q;
   logic                 bvalid_q;
   logic [1:0]           bresp_q;
   // Read channel state.
   logic                 rvalid_q;
   logic [31:0]          rdata_q;
   logic [1:0]           rresp_q;
   // Command staging.
   logic [31:0]          cmd_q;
   logic [31:0]          addr_q;
   logic [31:0]          ctrl_q;
   logic                 fire_q;
   logic                 busy_q;
   logic                 refused_q;
   logic                 bank_open_q;
   logic                 sr_in_q;
   logic                 pd_in_q;
   logic [9:0]           guard_q;
   logic                 do_write;
   logic                 cmd_ok;
   dcd_pkg::dcd_cmd_t    cmd_code;

   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
      is_reg = (a[7:2] == off[7:2]);
   endfunction : is_reg

   assign axi_rsp_o.awready = !aw_hold_q && !bvalid_q;
   assign axi_rsp_o.wready  = !w_hold_q && !bvalid_q;
   assign axi_rsp_o.bvalid  = bvalid_q;
   assign axi_rsp_o.bresp   = bresp_q;
   assign axi_rsp_o.arready = !rvalid_q;
   assign axi_rsp_o.rvalid  = rvalid_q;
   assign axi_rsp_o.rdata   = rdata_q;
   assign axi_rsp_o.rresp   = rresp_q;

   assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
   assign cmd_code = dcd_pkg::dcd_cmd_t'(w_data_q[dcd_pkg::CMD_CODE_LSB +: 4]);

   // Refuses a command that the device state forbids at this moment.
   always_comb begin
      cmd_ok = !busy_q;
      unique case (cmd_code)
         dcd_pkg::DCD_SR_ENTER:
            cmd_ok = cmd_ok && !bank_open_q && !sr_in_q && !pd_in_q;
         dcd_pkg::DCD_SR_LEAVE:
            cmd_ok = cmd_ok && sr_in_q;
         dcd_pkg::DCD_SLEEP_IN:
            cmd_ok = cmd_ok && !sr_in_q && !pd_in_q;
         dcd_pkg::DCD_SLEEP_OUT:
            cmd_ok = cmd_ok && pd_in_q;
         dcd_pkg::DCD_STORE:
            cmd_ok = cmd_ok && !sr_in_q && !pd_in_q && (guard_q == '0);
         dcd_pkg::DCD_IDLE,
         dcd_pkg::DCD_DESELECT:
            cmd_ok = cmd_ok;
         default:
            cmd_ok = cmd_ok && !sr_in_q && !pd_in_q;
      endcase
      if (w_data_q[dcd_pkg::CMD_CODE_LSB +: 4] > 4'hE) begin
         cmd_ok = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         aw_hold_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_hold_q  <= 1'b0;
         w_data_q  <= 32'h0000_0000;
      end else begin
         if (axi_req_i.awvalid && axi_rsp_o.awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= axi_req_i.awaddr;
         end else if (do_write) begin
            aw_hold_q <= 1'b0;
         end
         if (axi_req_i.wvalid && axi_rsp_o.wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= axi_req_i.wdata;
         end else if (do_write) begin
            w_hold_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         bvalid_q  <= 1'b0;
         bresp_q   <= dcd_pkg::AXI_OKAY;
         cmd_q     <= 32'h0000_0000;
         addr_q    <= 32'h0000_0000;
         ctrl_q    <= dcd_pkg::CTRL_RST;
         fire_q    <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         fire_q <= 1'b0;
         if (bvalid_q && axi_req_i.bready) begin
            bvalid_q <= 1'b0;
         end
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= dcd_pkg::AXI_OKAY;
            if (is_reg(aw_addr_q, dcd_pkg::REG_CMD)) begin
               if (cmd_ok) begin
                  cmd_q     <= w_data_q;
                  fire_q    <= 1'b1;
                  refused_q <= 1'b0;
               end else begin
                  refused_q <= 1'b1;
                  bresp_q   <= dcd_pkg::AXI_SLVERR;
               end
            end else if (is_reg(aw_addr_q, dcd_pkg::REG_ADDR)) begin
               addr_q <= w_data_q;
            end else if (is_reg(aw_addr_q, dcd_pkg::REG_CTRL)) begin
               ctrl_q <= w_data_q;
            end else if (!is_reg(aw_addr_q, dcd_pkg::REG_STATUS)) begin
               bresp_q <= dcd_pkg::AXI_SLVERR;
            end
         end
      end
   end

   // Tracks device state as implied by the commands sent.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_q      <= 1'b0;
         bank_open_q <= 1'b0;
         sr_in_q     <= 1'b0;
         // Pins leave reset with clock enable low, so tracking starts in sleep.
         pd_in_q     <= 1'b1;
         guard_q     <= 10'h000;
      end else begin
         busy_q <= do_write && is_reg(aw_addr_q, dcd_pkg::REG_CMD) && cmd_ok;
         if (guard_q != '0) begin
            guard_q <= guard_q - 10'h001;
         end
         if (fire_q) begin
            unique case (dcd_pkg::dcd_cmd_t'(cmd_q[3:0]))
               dcd_pkg::DCD_ROW_OPEN:  bank_open_q <= 1'b1;
               dcd_pkg::DCD_ALL_CLOSE: bank_open_q <= 1'b0;
               dcd_pkg::DCD_SR_ENTER:  sr_in_q <= 1'b1;
               dcd_pkg::DCD_SR_LEAVE: begin
                  sr_in_q <= 1'b0;
                  guard_q <= dcd_pkg::SR_GUARD_CYC;
               end
               dcd_pkg::DCD_SLEEP_IN:  pd_in_q <= 1'b1;
               dcd_pkg::DCD_SLEEP_OUT: pd_in_q <= 1'b0;
               dcd_pkg::DCD_STORE,
               dcd_pkg::DCD_FETCH:
                  if (cmd_q[dcd_pkg::CMD_CLOSE_POS]) begin
                     bank_open_q <= 1'b0;
                  end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= dcd_pkg::AXI_OKAY;
      end else if (rvalid_q) begin
         if (axi_req_i.rready) begin
            rvalid_q <= 1'b0;
         end
      end else if (axi_req_i.arvalid) begin
         rvalid_q <= 1'b1;
         rresp_q  <= dcd_pkg::AXI_OKAY;
         if (is_reg(axi_req_i.araddr, dcd_pkg::REG_CMD)) begin
            rdata_q <= cmd_q;
         end else if (is_reg(axi_req_i.araddr, dcd_pkg::REG_ADDR)) begin
            rdata_q <= addr_q;
         end else if (is_reg(axi_req_i.araddr, dcd_pkg::REG_CTRL)) begin
            rdata_q <= ctrl_q;
         end else if (is_reg(axi_req_i.araddr, dcd_pkg::REG_STATUS)) begin
            rdata_q <= {16'h0000, guard_q, 1'b0, refused_q, pd_in_q, sr_in_q,
                        bank_open_q, busy_q};
         end else begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= dcd_pkg::AXI_SLVERR;
         end
      end
   end

   // Field widths follow the package widths for the chosen density.
   dcd_pin_drive u_drive (
      .mclk_i    (mclk_i),
      .reset_i   (reset_i),
      .fire_i    (fire_q),
      .cmd_i     (dcd_pkg::dcd_cmd_t'(cmd_q[3:0])),
      .bank_i    (cmd_q[dcd_pkg::CMD_BANK_LSB +: dcd_pkg::BANK_W]),
      .addr_i    (addr_q[dcd_pkg::ADDR_W-1:0]),
      .chop_i    (cmd_q[dcd_pkg::CMD_CHOP_POS]),
      .close_i   (cmd_q[dcd_pkg::CMD_CLOSE_POS]),
      .reset_n_i (ctrl_q[0]),
      .term_i    (ctrl_q[1] && !sr_in_q),
      .pins_o    (pins_o)
   );

endmodule : dcd_ctrl

// *** bench/dcd_ctrl_assertions.sv ***
// Port checker for the command controller.
`timescale 1ns/100ps
module dcd_ctrl_assertions (
   input wire logic                  mclk_i,
   input wire logic                  reset_i,
   input wire dcd_pkg::dcd_axi_req_t axi_req_i,
   input wire dcd_pkg::dcd_axi_rsp_t axi_rsp_o,
   input wire dcd_pkg::dcd_pins_t    pins_o
);
   logic       idle_cmd, self_renew_enter, wr, act, shut, sr_q, open_q;
   logic [9:0] gd_q;
   assign idle_cmd  = pins_o.ras_n & pins_o.cas_n & pins_o.we_n;
   assign self_renew_enter  = !pins_o.cs_n & !pins_o.ras_n & !pins_o.cas_n & pins_o.we_n;
   assign wr   = !pins_o.cs_n & pins_o.ras_n & !pins_o.cas_n & !pins_o.we_n;
   assign act  = !pins_o.cs_n & !pins_o.ras_n & pins_o.cas_n & pins_o.we_n;
   assign shut = !pins_o.cs_n & (pins_o.ras_n ^ pins_o.cas_n) & pins_o.addr[10]
                 & !(pins_o.cas_n & pins_o.we_n);
   // Tracks self-renew residency and the store guard that follows its exit.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sr_q   <= 1'b0;
         open_q <= 1'b0;
         gd_q   <= 10'h000;
      end else begin
         sr_q   <= (sr_q | (self_renew_enter & !pins_o.cke)) & !(sr_q & pins_o.cke);
         open_q <= (open_q | act) & !shut;
         gd_q   <= (sr_q & pins_o.cke) ? 10'(dcd_pkg::SR_WRITE_GUARD_NCK - 1)
                                       : gd_q - 10'(gd_q != 10'h000);
      end
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);
   a_cmd_one_cyc: assert property (!pins_o.cs_n && !idle_cmd |=> !pins_o.cs_n && idle_cmd)
      else $error("command held past one cycle");
   a_cke_fall_ok: assert property ($fell(pins_o.cke) |-> idle_cmd || self_renew_enter)
      else $error("bad command at clock enable fall");
   a_cke_rise_ok: assert property ($rose(pins_o.cke) |-> idle_cmd)
      else $error("bad command at clock enable rise");
   a_sleep_quiet: assert property (!pins_o.cke && !$past(pins_o.cke) |-> idle_cmd)
      else $error("command while clock enable low");
   a_store_guard: assert property (wr |-> gd_q == 10'h000)
      else $error("store too soon after self-renew exit");
   a_term_off_sr: assert property (sr_q && $past(sr_q) |-> !pins_o.termination_ctl)
      else $error("termination on in self-renew");
   a_sre_all_idle: assert property (self_renew_enter && !pins_o.cke |-> !open_q)
      else $error("self-renew entry with a bank open");
   a_unmapped_err: assert property ($rose(axi_rsp_o.rvalid)
      && $past(axi_req_i.araddr[7:2]) > 6'h03
      |-> axi_rsp_o.rresp == dcd_pkg::AXI_SLVERR) else $error("unmapped read not refused");
endmodule : dcd_ctrl_assertions

// *** bench/dcd_dev_model.sv ***
// Device model that decodes the controller pins into commands.
`timescale 1ns/100ps
module dcd_dev_model (
   input  wire logic                  mclk_i,
   input  wire dcd_pkg::dcd_pins_t    pins_i,
   output dcd_pkg::dcd_cmd_t          cmd_o,
   output logic [dcd_pkg::ADDR_W-1:0] addr_o,
   output logic [dcd_pkg::BANK_W-1:0] bank_o,
   output logic                       seen_o
);
   logic              pcke_q, sr_q, rst_n;
   dcd_pkg::dcd_cmd_t c;
   assign rst_n = pins_i.reset_n;
   always_comb begin
      c = dcd_pkg::DCD_IDLE;
      if (pcke_q && !pins_i.cke) begin
         c = pins_i.ras_n ? dcd_pkg::DCD_SLEEP_IN : dcd_pkg::DCD_SR_ENTER;
      end else if (!pcke_q && pins_i.cke) begin
         c = sr_q ? dcd_pkg::DCD_SR_LEAVE : dcd_pkg::DCD_SLEEP_OUT;
      end else if (pins_i.cs_n) begin
         c = dcd_pkg::DCD_DESELECT;
      end else if (pins_i.cke) begin
         case ({pins_i.ras_n, pins_i.cas_n, pins_i.we_n})
            3'h0: c = dcd_pkg::DCD_CFG_LOAD;
            3'h1: c = dcd_pkg::DCD_REFRESH;
            3'h2: c = pins_i.addr[10] ? dcd_pkg::DCD_ALL_CLOSE : dcd_pkg::DCD_CLOSE;
            3'h3: c = dcd_pkg::DCD_ROW_OPEN;
            3'h4: c = dcd_pkg::DCD_STORE;
            3'h5: c = dcd_pkg::DCD_FETCH;
            3'h6: c = pins_i.addr[10] ? dcd_pkg::DCD_CAL_LONG : dcd_pkg::DCD_CAL_SHORT;
            default: c = dcd_pkg::DCD_IDLE;
         endcase
      end
   end
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pcke_q <= 1'b0;
         sr_q   <= 1'b0;
         seen_o <= 1'b0;
      end else begin
         pcke_q <= pins_i.cke;
         sr_q   <= (sr_q | (c == dcd_pkg::DCD_SR_ENTER)) & (c != dcd_pkg::DCD_SR_LEAVE);
         seen_o <= (c != dcd_pkg::DCD_IDLE) && (c != dcd_pkg::DCD_DESELECT);
      end
   end
   always_ff @(posedge mclk_i) begin
      cmd_o  <= c;
      addr_o <= pins_i.addr;
      bank_o <= pins_i.bank;
   end
endmodule : dcd_dev_model

// *** bench/tb_top.sv ***
// Testbench for the command controller against the device model.
`timescale 1ns/100ps
module tb_top;
   logic                  mclk_i;
   logic                  reset_i;
   dcd_pkg::dcd_axi_req_t req;
   dcd_pkg::dcd_axi_rsp_t rsp;
   dcd_pkg::dcd_pins_t    pins;
   dcd_pkg::dcd_cmd_t     cmd;
   logic [14:0]           addr;
   logic [14:0]           ar;
   logic [2:0]            bank;
   logic                  seen;
   logic [31:0]           rd;
   logic [1:0]            rr;
   int                    error_cnt = 0;
   int                    samples_checked = 0;
   dcd_ctrl i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .axi_req_i(req), .axi_rsp_o(rsp),
      .pins_o(pins));
   dcd_dev_model i_dev (.mclk_i(mclk_i), .pins_i(pins), .cmd_o(cmd), .addr_o(addr),
      .bank_o(bank), .seen_o(seen));
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   task automatic end_of_test;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk
   task automatic chk_cmd(input dcd_pkg::dcd_cmd_t g, input dcd_pkg::dcd_cmd_t e);
      chk(32'(g), 32'(e), "decoded command");
   endtask : chk_cmd
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w, b;
      int   n;
      @(posedge mclk_i);
      {req.awaddr, req.wdata, req.wstrb} <= {a, d, 4'hF};
      {req.awvalid, req.wvalid, req.bready} <= 3'h7;
      b = 1'b0;
      for (n = 0; n < 50 && !b; n++) begin
         @(negedge mclk_i);
         {aw, w} = {req.awvalid & rsp.awready, req.wvalid & rsp.wready};
         {b, r} = {rsp.bvalid, rsp.bresp};
         @(posedge mclk_i);
         if (aw) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
      end
      req.bready <= 1'b0;
      chk(32'(b), 32'h1, "write timeout");
      if (!b) end_of_test();
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_hit, v;
      int   n;
      @(posedge mclk_i);
      {req.araddr, req.arvalid, req.rready} <= {a, 2'h3};
      v = 1'b0;
      for (n = 0; n < 50 && !v; n++) begin
         @(negedge mclk_i);
         ar_hit = req.arvalid & rsp.arready;
         {v, d, r} = {rsp.rvalid, rsp.rdata, rsp.rresp};
         @(posedge mclk_i);
         if (ar_hit) req.arvalid <= 1'b0;
      end
      req.rready <= 1'b0;
      chk(32'(v), 32'h1, "read timeout");
      if (!v) end_of_test();
   endtask : axi_rd
   // Flag bits: accept expected, chop bit, autoclose bit.
   task automatic do_cmd(input dcd_pkg::dcd_cmd_t k, input logic [2:0] b, input logic [2:0] f);
      logic [1:0] r;
      logic [1:0] e;
      int         n;
      e = f[2] ? dcd_pkg::AXI_OKAY : dcd_pkg::AXI_SLVERR;
      axi_wr(dcd_pkg::REG_CMD, {14'h0, f[0], f[1], 5'h0, b, 4'h0, k}, r);
      chk(32'(r), 32'(e), "write response");
      if (f[2]) begin
         for (n = 0; n < 20 && seen !== 1'b1; n++) @(negedge mclk_i);
         chk(32'(n < 20), 32'h1, "no command on pins");
         if (n == 20) end_of_test();
         chk_cmd(cmd, k);
         if (k inside {dcd_pkg::DCD_STORE, dcd_pkg::DCD_FETCH}) begin
            chk(32'({addr[12], addr[10], bank}), 32'({f[1:0], b}), "burst flags");
            chk(32'(addr[9:0]), 32'(ar[9:0]), "column");
         end
         if (k inside {dcd_pkg::DCD_ROW_OPEN, dcd_pkg::DCD_CFG_LOAD})
            chk(32'({bank, addr}), 32'({b, ar}), "row or code");
      end else begin
         repeat (2) @(negedge mclk_i);
         chk(32'(seen), 32'h0, "refused command on pins");
      end
   endtask : do_cmd
   initial begin
      reset_i = 1'b1;
      req     = '0;
      ar      = 15'h1555;
      repeat (3) @(posedge mclk_i);
      reset_i <= 1'b0;
      axi_rd(dcd_pkg::REG_CTRL, rd, rr);
      chk(rd, dcd_pkg::CTRL_RST, "control reset value");
      axi_rd(8'h10, rd, rr);
      chk(32'(rr), 32'(dcd_pkg::AXI_SLVERR), "unmapped read");
      axi_wr(8'h14, 32'h0, rr);
      chk(32'(rr), 32'(dcd_pkg::AXI_SLVERR), "unmapped write");
      axi_wr(dcd_pkg::REG_CTRL, 32'h2, rr);
      repeat (2) @(negedge mclk_i);
      chk(32'({pins.reset_n, pins.termination_ctl}), 32'h1, "reset pin");
      axi_wr(dcd_pkg::REG_CTRL, 32'h3, rr);
      axi_wr(dcd_pkg::REG_ADDR, 32'(ar), rr);
      axi_rd(dcd_pkg::REG_ADDR, rd, rr);
      chk(rd, 32'(ar), "address readback");
      if (pins.cke !== 1'b1) do_cmd(dcd_pkg::DCD_SLEEP_OUT, 3'h0, 3'h4);
      do_cmd(dcd_pkg::DCD_CFG_LOAD, 3'h2, 3'h4);
      do_cmd(dcd_pkg::DCD_REFRESH, 3'h0, 3'h4);
      do_cmd(dcd_pkg::DCD_CAL_LONG, 3'h0, 3'h4);
      do_cmd(dcd_pkg::DCD_CAL_SHORT, 3'h0, 3'h4);
      axi_wr(dcd_pkg::REG_CMD, 32'(dcd_pkg::DCD_DESELECT), rr);
      @(negedge mclk_i);
      chk(32'({rr, pins.cs_n}), 32'h1, "deselect on pins");
      @(negedge mclk_i);
      chk_cmd(cmd, dcd_pkg::DCD_DESELECT);
      axi_wr(dcd_pkg::REG_CMD, 32'(dcd_pkg::DCD_IDLE), rr);
      repeat (2) @(negedge mclk_i);
      chk(32'({rr, seen, pins.cs_n}), 32'h0, "idle accepted");
      do_cmd(dcd_pkg::DCD_ROW_OPEN, 3'h5, 3'h4);
      do_cmd(dcd_pkg::DCD_STORE, 3'h5, 3'h4);
      do_cmd(dcd_pkg::DCD_FETCH, 3'h5, 3'h6);
      do_cmd(dcd_pkg::DCD_SR_ENTER, 3'h0, 3'h0);
      do_cmd(dcd_pkg::DCD_STORE, 3'h5, 3'h7);
      do_cmd(dcd_pkg::DCD_ROW_OPEN, 3'h3, 3'h4);
      do_cmd(dcd_pkg::DCD_CLOSE, 3'h3, 3'h4);
      do_cmd(dcd_pkg::DCD_ALL_CLOSE, 3'h0, 3'h4);
      do_cmd(dcd_pkg::DCD_SR_ENTER, 3'h0, 3'h4);
      axi_rd(dcd_pkg::REG_STATUS, rd, rr);
      chk(32'(rd[2]), 32'h1, "self-renew status");
      do_cmd(dcd_pkg::DCD_FETCH, 3'h0, 3'h0);
      do_cmd(dcd_pkg::DCD_SR_LEAVE, 3'h0, 3'h4);
      do_cmd(dcd_pkg::DCD_STORE, 3'h1, 3'h0);
      repeat (520) @(posedge mclk_i);
      do_cmd(dcd_pkg::DCD_STORE, 3'h1, 3'h5);
      do_cmd(dcd_pkg::DCD_SLEEP_IN, 3'h0, 3'h4);
      do_cmd(dcd_pkg::DCD_ROW_OPEN, 3'h1, 3'h0);
      do_cmd(dcd_pkg::DCD_SLEEP_OUT, 3'h0, 3'h4);
      end_of_test();
   end
endmodule : tb_top
bind dcd_ctrl dcd_ctrl_assertions i_chk (.mclk_i(mclk_i), .reset_i(reset_i),
   .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .pins_o(pins_o));
